// ==== logic/vbi2c_master.sv ====
// two-wire host controller for the video buffer control registers
// Contract
// - start is data falling while clock high
// - send 7-bit address then direction, msb first
// - data stable while clock high, sampled then
// - each byte eight bits plus acknowledge
// - stop is data rising while clock high
// - write: release data line in acknowledge slot
// - one data byte per write, then stop
// - read: slave acks address then transmits
// - end read with not-acknowledge then stop
// - only one data byte per read
// - run at fast mode rate at most
// - write is subaddress plus exactly one byte
`timescale 1ns/10ps
module vbi2c_master
    import vbi2c_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic       cmd_valid,
    output logic            cmd_ready,
    input  wire logic       cmd_read,
    input  wire logic [1:0] cmd_dev_sel,
    input  wire logic [7:0] cmd_subaddr,
    input  wire logic [7:0] cmd_wdata,
    output logic            resp_valid,
    output logic [7:0]      resp_rdata,
    output logic            resp_nack,
    output logic            resp_bad,
    output logic            scl_o,
    output logic            scl_oe,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe
);
    vbi2c_state_type state;
    vbi2c_state_type next_state;
    logic [1:0]      qtr;
    logic [1:0]      next_qtr;
    logic [3:0]      bit_cnt;
    logic [3:0]      next_bit_cnt;
    logic [1:0]      idx;
    logic [1:0]      next_idx;
    logic [7:0]      shift;
    logic [7:0]      next_shift;
    logic            ack_high;
    logic            next_ack_high;
    logic            is_read;
    logic            next_is_read;
    logic [1:0]      sel;
    logic [1:0]      next_sel;
    logic [7:0]      sub;
    logic [7:0]      next_sub;
    logic [7:0]      wdata;
    logic [7:0]      next_wdata;
    logic            next_ready;
    logic            next_resp_valid;
    logic [7:0]      next_rdata;
    logic            next_nack;
    logic            next_bad;
    logic            next_scl_oe;
    logic            next_sda_oe;
    logic            sda_meta;
    logic            sda_sync;
    logic            rx;
    logic            tick;

    vbi2c_tick_if tk ();

    vbi2c_divider u_div (
        .sys_clk (sys_clk),
        .rst     (rst),
        .tk      (tk.gen)
    );

    assign tk.run = (state != ST_IDLE) && (state != ST_DONE);
    assign tick   = tk.tick;
    assign rx     = is_read && (idx == BYTE_RDATA);

    // byte put on the wire for each step of a transfer
    function automatic logic [7:0] tx_byte(input logic [1:0] i, input logic rd,
                                           input logic [1:0] s, input logic [7:0] sa,
                                           input logic [7:0] wd);
        logic [7:0] b;
        b = 8'hFF;
        case (i)
            BYTE_ADDR:  b = {DEV_ADDR_FIXED, s, DIR_WRITE};
            BYTE_SUB:   b = sa;
            BYTE_THIRD: b = rd ? {DEV_ADDR_FIXED, s, DIR_READ} : wd;
            default:    b = 8'hFF;
        endcase
        return b;
    endfunction

    // pin synchroniser; the line is only looked at well after it settles
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sda_meta <= 1'b1;
            sda_sync <= 1'b1;
        end else begin
            sda_meta <= sda_i;
            sda_sync <= sda_meta;
        end
    end

    always_comb begin
        next_state      = state;
        next_qtr        = qtr;
        next_bit_cnt    = bit_cnt;
        next_idx        = idx;
        next_shift      = shift;
        next_ack_high   = ack_high;
        next_is_read    = is_read;
        next_sel        = sel;
        next_sub        = sub;
        next_wdata      = wdata;
        next_ready      = 1'b0;
        next_resp_valid = 1'b0;
        next_rdata      = resp_rdata;
        next_nack       = resp_nack;
        next_bad        = resp_bad;
        next_scl_oe     = scl_oe;
        next_sda_oe     = sda_oe;
        case (state)
            ST_IDLE: begin
                // bus left free between transfers
                next_ready  = 1'b1;
                next_scl_oe = 1'b0;
                next_sda_oe = 1'b0;
                if (cmd_valid && cmd_ready) begin
                    next_ready   = 1'b0;
                    next_is_read = cmd_read;
                    next_sel     = cmd_dev_sel;
                    next_sub     = cmd_subaddr;
                    next_wdata   = cmd_wdata;
                    next_idx     = BYTE_ADDR;
                    next_qtr     = QTR_0;
                    next_nack    = 1'b0;
                    if (cmd_subaddr < SUBADDR_FIRST || cmd_subaddr > SUBADDR_LAST) begin
                        next_bad   = 1'b1;
                        next_state = ST_DONE;
                    end else begin
                        next_bad   = 1'b0;
                        next_state = ST_START;
                    end
                end
            end
            ST_START: begin
                if (tick) begin
                    next_qtr = qtr + 2'h1;
                    case (qtr)
                        QTR_0: begin
                            next_scl_oe = 1'b1;
                            next_sda_oe = 1'b0;
                        end
                        QTR_1: next_scl_oe = 1'b0;
                        QTR_2: next_sda_oe = 1'b1;
                        default: begin
                            next_scl_oe  = 1'b1;
                            next_bit_cnt = BIT_FIRST;
                            next_shift   = tx_byte(idx, is_read, sel, sub, wdata);
                            next_state   = ST_BIT;
                        end
                    endcase
                end
            end
            ST_BIT: begin
                if (tick) begin
                    next_qtr = qtr + 2'h1;
                    case (qtr)
                        QTR_0: begin
                            // ack slot always released: slave acks writes, we nack reads
                            if (bit_cnt == BIT_ACK || rx) begin
                                next_sda_oe = 1'b0;
                            end else begin
                                next_sda_oe = ~shift[7];
                            end
                        end
                        QTR_1: next_scl_oe = 1'b0;
                        QTR_2: begin
                            if (bit_cnt == BIT_ACK) begin
                                next_ack_high = sda_sync;
                            end else begin
                                next_shift = {shift[6:0], sda_sync};
                            end
                        end
                        default: begin
                            next_scl_oe = 1'b1;
                            if (bit_cnt != BIT_ACK) begin
                                next_bit_cnt = bit_cnt + 4'h1;
                            end else if (rx) begin
                                next_rdata = shift;
                                next_state = ST_STOP;
                            end else if (ack_high) begin
                                next_nack  = 1'b1;
                                next_state = ST_STOP;
                            end else if (!is_read && idx == BYTE_THIRD) begin
                                next_state = ST_STOP;
                            end else if (is_read && idx == BYTE_SUB) begin
                                next_idx   = BYTE_THIRD;
                                next_state = ST_START;
                            end else begin
                                next_idx     = idx + 2'h1;
                                next_bit_cnt = BIT_FIRST;
                                next_shift   = tx_byte(idx + 2'h1, is_read, sel, sub, wdata);
                            end
                        end
                    endcase
                end
            end
            ST_STOP: begin
                if (tick) begin
                    next_qtr = qtr + 2'h1;
                    case (qtr)
                        QTR_0: begin
                            next_scl_oe = 1'b1;
                            next_sda_oe = 1'b1;
                        end
                        QTR_1: next_scl_oe = 1'b0;
                        QTR_2: next_sda_oe = 1'b0;
                        default: next_state = ST_DONE;
                    endcase
                end
            end
            ST_DONE: begin
                next_resp_valid = 1'b1;
                next_state      = ST_IDLE;
            end
            default: next_state = ST_IDLE;
        endcase
    end

    // quarter pacing comes from the divider at the fast mode rate
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state      <= ST_IDLE;
            qtr        <= QTR_0;
            bit_cnt    <= BIT_FIRST;
            idx        <= BYTE_ADDR;
            shift      <= 8'hFF;
            ack_high   <= 1'b0;
            is_read    <= 1'b0;
            sel        <= 2'h0;
            sub        <= 8'h00;
            wdata      <= 8'h00;
            cmd_ready  <= 1'b0;
            resp_valid <= 1'b0;
            resp_rdata <= 8'h00;
            resp_nack  <= 1'b0;
            resp_bad   <= 1'b0;
            scl_oe     <= 1'b0;
            sda_oe     <= 1'b0;
            scl_o      <= 1'b0;
            sda_o      <= 1'b0;
        end else begin
            state      <= next_state;
            qtr        <= next_qtr;
            bit_cnt    <= next_bit_cnt;
            idx        <= next_idx;
            shift      <= next_shift;
            ack_high   <= next_ack_high;
            is_read    <= next_is_read;
            sel        <= next_sel;
            sub        <= next_sub;
            wdata      <= next_wdata;
            cmd_ready  <= next_ready;
            resp_valid <= next_resp_valid;
            resp_rdata <= next_rdata;
            resp_nack  <= next_nack;
            resp_bad   <= next_bad;
            scl_oe     <= next_scl_oe;
            sda_oe     <= next_sda_oe;
            scl_o      <= 1'b0;
            sda_o      <= 1'b0;
        end
    end
endmodule

// ==== logic/vbi2c_pkg.sv ====
// constants and types for the video buffer two-wire host controller
package vbi2c_pkg;
    localparam logic [4:0] DEV_ADDR_FIXED     = 5'h0B;
    localparam logic       DIR_WRITE          = 1'h0;
    localparam logic       DIR_READ           = 1'h1;
    localparam logic [7:0] SUBADDR_FIRST      = 8'h01;
    localparam logic [7:0] SUBADDR_LAST       = 8'h04;
    localparam int         SYS_CLK_PERIOD_NS  = 4;
    localparam int         BIT_RATE_KBPS      = 400;
    localparam int         BIT_PERIOD_NS      = 1000000 / BIT_RATE_KBPS;
    localparam int         QUARTER_CYCLES     =
        (BIT_PERIOD_NS + 4 * SYS_CLK_PERIOD_NS - 1) / (4 * SYS_CLK_PERIOD_NS);
    localparam logic [7:0] QUARTER_COUNT_LAST = 8'(QUARTER_CYCLES - 1);
    localparam logic [3:0] BIT_FIRST          = 4'h0;
    localparam logic [3:0] BIT_ACK            = 4'h8;
    localparam logic [1:0] BYTE_ADDR          = 2'h0;
    localparam logic [1:0] BYTE_SUB           = 2'h1;
    localparam logic [1:0] BYTE_THIRD         = 2'h2;
    localparam logic [1:0] BYTE_RDATA         = 2'h3;
    localparam logic [1:0] QTR_0              = 2'h0;
    localparam logic [1:0] QTR_1              = 2'h1;
    localparam logic [1:0] QTR_2              = 2'h2;
    localparam logic [1:0] QTR_3              = 2'h3;

    typedef enum logic [4:0] {
        ST_IDLE  = 5'h01,
        ST_START = 5'h02,
        ST_BIT   = 5'h04,
        ST_STOP  = 5'h08,
        ST_DONE  = 5'h10
    } vbi2c_state_type;
endpackage

// ==== logic/vbi2c_tick_if.sv ====
// quarter-bit tick carrier between the controller and its divider
`timescale 1ns/10ps
interface vbi2c_tick_if;
    logic run;
    logic tick;
    modport gen (input run, output tick);
    modport ctl (output run, input tick);
endinterface

// ==== logic/vbi2c_divider.sv ====
// divider that paces the serial clock in quarter-bit steps
`timescale 1ns/10ps
module vbi2c_divider
    import vbi2c_pkg::*;
(
    input  wire logic sys_clk,
    input  wire logic rst,
    vbi2c_tick_if.gen tk
);
    logic [7:0] count;
    logic [7:0] next_count;
    logic       tick;
    logic       next_tick;

    always_comb begin
        next_count = count;
        next_tick  = 1'b0;
        if (!tk.run) begin
            next_count = 8'h00;
        end else if (count == QUARTER_COUNT_LAST) begin
            next_count = 8'h00;
            next_tick  = 1'b1;
        end else begin
            next_count = count + 8'h01;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            count <= 8'h00;
            tick  <= 1'b0;
        end else begin
            count <= next_count;
            tick  <= next_tick;
        end
    end

    assign tk.tick = tick;
endmodule

// ==== tb/vbi2c_master_sva.sv ====
// assertions on the two-wire host controller ports
`timescale 1ns/10ps
module vbi2c_master_sva (
    input wire logic       sys_clk,
    input wire logic       rst,
    input wire logic       cmd_valid,
    input wire logic       cmd_ready,
    input wire logic [7:0] cmd_subaddr,
    input wire logic       resp_valid,
    input wire logic       resp_nack,
    input wire logic       resp_bad,
    input wire logic       scl_oe,
    input wire logic       sda_oe
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    localparam int QMIN = 150;
    logic       take, bad, scl_q;
    logic [7:0] run_len, next_run_len;
    assign take = cmd_valid && cmd_ready;
    assign bad  = cmd_subaddr < 8'h01 || cmd_subaddr > 8'h04;
    // saturating, so a long idle never wraps into a short phase
    always_comb begin
        next_run_len = run_len + 8'(run_len != 8'hFF);
        if (rst) begin
            next_run_len = 8'hFF;
        end else if (scl_oe != scl_q) begin
            next_run_len = 8'h01;
        end
    end
    always_ff @(posedge sys_clk) begin
        run_len <= next_run_len;
        scl_q   <= scl_oe;
    end
    AST_IDLE_FREE: assert property (cmd_ready |-> !scl_oe && !sda_oe)
        else $error("bus held while idle");
    AST_TAKE_DROP: assert property (take |=> !cmd_ready)
        else $error("ready stayed high after take");
    AST_BAD_QUIET: assert property (take && bad |->
        (!scl_oe && !sda_oe)[*3] ##0 (resp_valid && resp_bad)) else $error("bad subaddress");
    AST_GOOD_STARTS: assert property (take && !bad |-> ##[1:200] scl_oe)
        else $error("transfer never began");
    AST_START_FORM: assert property ($rose(sda_oe) && !scl_oe |-> ##[150:170] scl_oe)
        else $error("start not followed by clock low");
    AST_STOP_DONE: assert property ($fell(sda_oe) && !scl_oe |-> ##[150:180] resp_valid)
        else $error("stop not followed by response");
    AST_RESP_PULSE: assert property (resp_valid |=> !resp_valid && cmd_ready)
        else $error("response not a single pulse");
    AST_NACK_HOLD: assert property (resp_nack && !take |=> resp_nack)
        else $error("nack flag dropped early");
    AST_SCL_PHASE: assert property (scl_oe != scl_q |-> run_len >= QMIN)
        else $error("serial clock phase too short");
endmodule
bind vbi2c_master vbi2c_master_sva i_vbi2c_master_sva (
    .sys_clk, .rst, .cmd_valid, .cmd_ready, .cmd_subaddr, .resp_valid, .resp_nack,
    .resp_bad, .scl_oe, .sda_oe);

// ==== tb/vbi2c_slave_model.sv ====
// behavioural model of the video buffer serial register port
`timescale 1ns/10ps
module vbi2c_slave_model #(
    parameter logic [7:0] PWRUP_ON_VALUE = 8'h04
) (
    input  wire logic scl,
    input  wire logic sda,
    input  wire logic addr_select_hi,
    input  wire logic addr_select_lo,
    input  wire logic power_up_config_pin,
    output logic      sda_oe
);
    logic [7:0] regs [1:4];
    logic [7:0] sh, sub, tx, pend;
    logic       pend_v = 1'b0;
    int         state  = 0;
    int         bitn   = 0;
    initial begin
        sda_oe = 1'b0;
        #1;
        foreach (regs[i]) regs[i] = power_up_config_pin ? PWRUP_ON_VALUE : 8'h00;
    end
    // a start mid-byte drops any pending write
    always @(negedge sda) if (scl) begin
        state = 1;
        bitn = 0;
        pend_v = 1'b0;
        sda_oe = 1'b0;
    end
    always @(posedge sda) if (scl) begin
        if (pend_v) regs[sub] = pend;
        pend_v = 1'b0;
        state = 0;
    end
    always @(posedge scl) if (state != 0 && bitn < 8) begin
        sh = {sh[6:0], sda};
        bitn++;
    end
    always @(negedge scl) begin
        if (state != 0 && bitn == 8) begin
            bitn = 9;
            sda_oe = 1'b0;
            case (state)
                1: if (sh[7:1] == {5'b01011, addr_select_hi, addr_select_lo}) begin
                    sda_oe = 1'b1;
                    state = sh[0] ? 4 : 2;
                    tx = regs[sub];
                end else state = 0;
                2: if (sh >= 8'h01 && sh <= 8'h04) begin
                    sda_oe = 1'b1;
                    sub = sh;
                    state = 3;
                end else state = 0;
                3: begin
                    sda_oe = 1'b1;
                    pend = sh;
                    pend_v = 1'b1;
                    state = 5;
                end
                default: state = 5;
            endcase
        end else if (state != 0 && bitn == 9) begin
            bitn = 0;
            sda_oe = state == 4 && !tx[7];
        end else if (state == 4 && bitn < 8) sda_oe = !tx[7 - bitn];
    end
endmodule

// ==== tb/test_vbi2c_master.sv ====
// self-checking bench for the two-wire host controller
`timescale 1ns/10ps
module test_vbi2c_master;
    localparam logic [7:0] PWRUP_ON = 8'h04;
    logic       sys_clk, cmd_ready, resp_valid, resp_nack, resp_bad, pwrup_pin;
    logic       scl_o, scl_oe, sda_o, sda_oe, dev_sda_oe;
    logic       rst         = 1'b1;
    logic       cmd_valid   = 1'b0;
    logic       cmd_read    = 1'b0;
    logic [1:0] cmd_dev_sel = 2'h0;
    logic [7:0] cmd_subaddr = 8'h00;
    logic [7:0] cmd_wdata   = 8'h00;
    logic [1:0] sel;
    logic [7:0] resp_rdata, sa, wd;
    logic [7:0] bads [3];
    int         n_fail      = 0;
    int         n_checks    = 0;
    int         exp_regs [1:4];
    // open drain: any driver low wins, pull-up otherwise
    wire        scl = !(scl_oe && !scl_o);
    wire        sda = !(sda_oe && !sda_o) && !dev_sda_oe;
    vbi2c_master i_vbi2c_master (
        .sys_clk, .rst, .cmd_valid, .cmd_ready, .cmd_read, .cmd_dev_sel, .cmd_subaddr,
        .cmd_wdata, .resp_valid, .resp_rdata, .resp_nack, .resp_bad, .scl_o, .scl_oe,
        .sda_i(sda), .sda_o, .sda_oe);
    vbi2c_slave_model #(.PWRUP_ON_VALUE(PWRUP_ON)) i_vbi2c_slave_model (
        .scl, .sda, .addr_select_hi(sel[1]), .addr_select_lo(sel[0]),
        .power_up_config_pin(pwrup_pin), .sda_oe(dev_sda_oe));
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic xfer(input logic rd, input logic [1:0] ds, input logic [7:0] s);
        int n;
        n = 0;
        cmd_valid   <= 1'b1;
        cmd_read    <= rd;
        cmd_dev_sel <= ds;
        cmd_subaddr <= s;
        cmd_wdata   <= wd;
        do @(posedge sys_clk); while (cmd_ready !== 1'b1);
        cmd_valid <= 1'b0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (resp_valid !== 1'b1 && n < 30000);
        if (n >= 30000) n_fail++;
    endtask
    initial begin
        void'($urandom(32'h708193cf));
        sel = 2'($urandom);
        pwrup_pin = 1'($urandom);
        sa = 8'($urandom_range(4, 1));
        wd = 8'($urandom);
        bads = '{8'h00, 8'h05, 8'($urandom_range(255, 5))};
        foreach (exp_regs[i]) exp_regs[i] = pwrup_pin ? PWRUP_ON : 8'h00;
        repeat (8) @(posedge sys_clk);
        check(8'({cmd_ready, resp_valid, scl_oe, sda_oe}), 8'h00);
        rst <= 1'b0;
        $display("reset test done");
        xfer(1'b1, sel, sa);
        check(resp_rdata, 8'(exp_regs[sa]));
        check(8'({resp_nack, resp_bad}), 8'h00);
        // open-drain clock and data outputs must never carry a high level
        check(8'({scl_o, sda_o}), 8'h00);
        $display("power-up read test done");
        xfer(1'b0, sel, sa);
        exp_regs[sa] = wd;
        check(8'({resp_nack, resp_bad}), 8'h00);
        wd = ~wd;
        // wrong select pins: nobody answers, nothing written
        xfer(1'b0, sel ^ 2'h1, sa);
        check(8'({resp_nack, resp_bad}), 8'h02);
        xfer(1'b1, sel, sa);
        check(resp_rdata, 8'(exp_regs[sa]));
        check(8'({resp_nack, resp_bad}), 8'h00);
        $display("write and readback test done");
        foreach (bads[i]) begin
            xfer(1'b0, sel, bads[i]);
            check(8'({resp_nack, resp_bad}), 8'h01);
        end
        $display("bad subaddress test done");
        print_verdict();
    end
    initial begin
        repeat (98000) @(posedge sys_clk);
        n_fail++;
        print_verdict();
    end
endmodule
